// ---- rtl/ppl_top.sv ----
// Port pin logic: ports one to three and the serial interface pins.
`timescale 1ns/100ps
module ppl_top
    import ppl_pkg::*;
#(
    parameter int W = ppl_pkg::PORT_W
) (
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          resetn,
    // Latch write port from the core.
    input  wire logic          p1_wr,
    input  wire logic          p2_wr,
    input  wire logic          p3_wr,
    input  wire logic [W-1:0]  wr_data,
    // Latch and pin readback.
    output logic [W-1:0]       port_one_latch,
    output logic [W-1:0]       port_two_latch,
    output logic [W-1:0]       port_three_latch,
    output logic [W-1:0]       p1_pin_rd,
    output logic [W-1:0]       p2_pin_rd,
    output logic [W-1:0]       p3_pin_rd,
    // Port one pins.
    input  wire logic [W-1:0]  p1_in,
    output logic [1:0]         p1_pull_low_oe_n,
    output logic [1:0]         p1_strong_pullup_oe_n,
    output logic [1:0]         p1_keeper_on,
    output logic [W-1:2]       p1_analog_sel,
    // Port one alternate functions.
    input  wire logic          pulse_width_out_zero_route,
    input  wire logic          pulse_width_out_one_route,
    input  wire logic          pulse_width_out_zero,
    input  wire logic          pulse_width_out_one,
    output logic               timer_two_count_in,
    output logic               timer_two_trigger_in,
    // Port two pins and external memory address.
    input  wire logic [W-1:0]  p2_in,
    input  wire logic          ext_access,
    input  wire logic [W-1:0]  ext_addr_byte,
    output logic [W-1:0]       p2_pull_low_oe_n,
    output logic [W-1:0]       p2_strong_pullup_oe_n,
    output logic [W-1:0]       p2_keeper_on,
    // Port three pins and alternate functions.
    input  wire logic [W-1:0]  p3_in,
    input  wire logic [W-1:0]  p3_alt_out,
    output logic [W-1:0]       p3_pull_low_oe_n,
    output logic [W-1:0]       p3_strong_pullup_oe_n,
    output logic [W-1:0]       p3_keeper_on,
    output logic               serial_rx_in,
    output logic               ext_interrupt_zero,
    output logic               ext_interrupt_one,
    output logic               timer_zero_count_in,
    output logic               pulse_width_ext_clock,
    output logic               timer_one_count_in,
    // Serial interface pins.
    input  wire logic          serial_iface_select,
    input  wire logic          i2c_master,
    input  wire logic          sw_sclk_out,
    input  wire logic          sw_serial_data_pin_out,
    input  wire logic          spi_sclk_out,
    input  wire logic          spi_serial_data_pin_out,
    input  wire logic          spi_serial_data_pin_drive,
    input  wire logic          spi_sclk_drive,
    input  wire logic          spi_miso_out,
    input  wire logic          spi_miso_drive,
    input  wire logic          serial_clock_pin_in,
    input  wire logic          serial_data_pin_in,
    input  wire logic          miso_pin_in,
    output logic               serial_clock_pin_oe_n,
    output logic               serial_clock_pin_out,
    output logic               serial_clock_strong_oe_n,
    output logic               serial_data_pin_oe_n,
    output logic               serial_data_pin_out,
    output logic               serial_data_strong_oe_n,
    output logic               miso_pin_oe_n,
    output logic               miso_pin_out,
    output logic               miso_strong_oe_n,
    output logic               spi_sclk_in,
    output logic               spi_serial_data_pin_in,
    output logic               spi_miso_in,
    output logic               i2c_sclk_in,
    output logic               i2c_serial_data_pin_in,
    output logic               sw_sclk_in,
    output logic               sw_serial_data_pin_in,
    // Slave select.
    input  wire logic          slave_select_n_in,
    output logic               slave_select_pullup_on,
    output logic               slave_select_n
);
    logic [W-1:0] p1_q, p1_d, p2_q, p2_d, p3_q, p3_d;
    logic [W-1:0] p1_s1_q, p1_s2_q, p2_s1_q, p2_s2_q, p3_s1_q, p3_s2_q;
    logic [4:0]   sr_s1_q, sr_s2_q;
    logic [1:0]   p1_lvl;
    logic [W-1:0] p2_lvl, p3_lvl;
    logic [1:0]   flt_out;
    logic [CNT_W-1:0] flt_cnt_q [2], flt_cnt_d [2];
    logic [1:0]   flt_q, flt_d;
    logic [W-1:0] p2_pp_n_q, p2_pp_n_d, p2_cell_st_n;

    // Latch writes; external accesses never touch the latches.
    always_comb begin
        p1_d = p1_wr ? wr_data : p1_q;
        p2_d = p2_wr ? wr_data : p2_q;
        p3_d = p3_wr ? wr_data : p3_q;
        p2_pp_n_d = ext_access ? ~ext_addr_byte : '1;
    end

    // Latches reset to all ones, which is analog input on port one high bits.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_q <= LATCH_RST;
            p2_q <= LATCH_RST;
            p3_q <= LATCH_RST;
            p2_pp_n_q <= '1;
        end else begin
            p1_q <= p1_d;
            p2_q <= p2_d;
            p3_q <= p3_d;
            p2_pp_n_q <= p2_pp_n_d;
        end
    end

    // Latch readback serves read-modify-write cycles.
    assign port_one_latch   = p1_q;
    assign port_two_latch   = p2_q;
    assign port_three_latch = p3_q;

    // Two-stage synchronisers; reset to the pulled-up idle level of the pins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_s1_q <= '1;
            p1_s2_q <= '1;
            p2_s1_q <= '1;
            p2_s2_q <= '1;
            p3_s1_q <= '1;
            p3_s2_q <= '1;
            sr_s1_q <= 5'h1f;
            sr_s2_q <= 5'h1f;
        end else begin
            p1_s1_q <= p1_in;
            p1_s2_q <= p1_s1_q;
            p2_s1_q <= p2_in;
            p2_s2_q <= p2_s1_q;
            p3_s1_q <= p3_in;
            p3_s2_q <= p3_s1_q;
            sr_s1_q <= {slave_select_n_in, miso_pin_in, serial_data_pin_in,
                        serial_clock_pin_in, 1'b1};
            sr_s2_q <= sr_s1_q;
        end
    end

    assign p1_pin_rd = p1_s2_q;
    assign p2_pin_rd = p2_s2_q;
    assign p3_pin_rd = p3_s2_q;

    // Port one low bits: pulse-width output overrides the latch.
    assign p1_lvl[0] = pulse_width_out_zero_route ? pulse_width_out_zero : p1_q[0];
    assign p1_lvl[1] = pulse_width_out_one_route ? pulse_width_out_one : p1_q[1];
    // Timer two inputs see the pin only while the latch holds one.
    assign timer_two_count_in   = p1_q[0] & p1_s2_q[0];
    assign timer_two_trigger_in = p1_q[1] & p1_s2_q[1];
    assign p1_analog_sel        = p1_q[W-1:2];

    // Port two follows the address byte during external access.
    assign p2_lvl = ext_access ? ext_addr_byte : p2_q;
    // Address ones drive high through the strong pull-up for push-pull.
    assign p2_strong_pullup_oe_n = p2_cell_st_n & p2_pp_n_q;
    // Port three outputs gated by the latch; bit 0 data, 1 clock, 6-7 strobes.
    assign p3_lvl = p3_q & p3_alt_out;

    // Alternate inputs read zero when the latch holds zero.
    assign serial_rx_in          = p3_q[0] & p3_s2_q[0];
    assign ext_interrupt_zero    = p3_q[2] & p3_s2_q[2];
    assign ext_interrupt_one     = p3_q[3] & p3_s2_q[3];
    assign timer_zero_count_in   = p3_q[4] & p3_s2_q[4];
    assign pulse_width_ext_clock = p3_q[4] & p3_s2_q[4];
    assign timer_one_count_in    = p3_q[5] & p3_s2_q[5];

    // Pull-up cells for port one low bits and all port two and port three bits.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_p1
            ppl_pin_cell u_cell (
                .clk                (clk),
                .resetn             (resetn),
                .level              (p1_lvl[gi]),
                .pin_sync           (p1_s2_q[gi]),
                .pull_low_oe_n      (p1_pull_low_oe_n[gi]),
                .strong_pullup_oe_n (p1_strong_pullup_oe_n[gi]),
                .keeper_on          (p1_keeper_on[gi])
            );
        end
        for (gi = 0; gi < W; gi++) begin : g_p23
            ppl_pin_cell u_p2 (
                .clk                (clk),
                .resetn             (resetn),
                .level              (p2_lvl[gi]),
                .pin_sync           (p2_s2_q[gi]),
                .pull_low_oe_n      (p2_pull_low_oe_n[gi]),
                .strong_pullup_oe_n (p2_cell_st_n[gi]),
                .keeper_on          (p2_keeper_on[gi])
            );
            ppl_pin_cell u_p3 (
                .clk                (clk),
                .resetn             (resetn),
                .level              (p3_lvl[gi]),
                .pin_sync           (p3_s2_q[gi]),
                .pull_low_oe_n      (p3_pull_low_oe_n[gi]),
                .strong_pullup_oe_n (p3_strong_pullup_oe_n[gi]),
                .keeper_on          (p3_keeper_on[gi])
            );
        end
    endgenerate

    // Glitch filter: output follows input once stable for longer than the filter time.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            flt_d[i]     = flt_q[i];
            flt_cnt_d[i] = '0;
            if (sr_s2_q[i+1] != flt_q[i]) begin
                flt_cnt_d[i] = flt_cnt_q[i] + 1'b1;
                if (flt_cnt_q[i] == CNT_W'(GLITCH_CYC - 1)) begin
                    flt_d[i]     = sr_s2_q[i+1];
                    flt_cnt_d[i] = '0;
                end
            end
        end
    end

    // Filter registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flt_q        <= 2'h3;
            flt_cnt_q[0] <= '0;
            flt_cnt_q[1] <= '0;
        end else begin
            flt_q        <= flt_d;
            flt_cnt_q[0] <= flt_cnt_d[0];
            flt_cnt_q[1] <= flt_cnt_d[1];
        end
    end

    assign flt_out      = flt_q;
    assign i2c_sclk_in  = flt_out[0];
    assign i2c_serial_data_pin_in = flt_out[1];
    assign spi_sclk_in  = sr_s2_q[1];
    assign spi_serial_data_pin_in = sr_s2_q[2];
    assign spi_miso_in  = sr_s2_q[3];
    assign sw_sclk_in   = sr_s2_q[1];
    assign sw_serial_data_pin_in  = sr_s2_q[2];

    // Serial pins: open-drain in I2C mode, SPI push-pull otherwise.
    always_comb begin
        serial_clock_pin_out     = 1'b0;
        serial_data_pin_out      = 1'b0;
        serial_clock_strong_oe_n = 1'b1;
        serial_data_strong_oe_n  = 1'b1;
        serial_clock_pin_oe_n    = 1'b1;
        serial_data_pin_oe_n     = 1'b1;
        if (serial_iface_select) begin
            serial_clock_pin_oe_n    = !(spi_sclk_drive && !spi_sclk_out);
            serial_clock_strong_oe_n = !(spi_sclk_drive && spi_sclk_out);
            serial_data_pin_oe_n     = !(spi_serial_data_pin_drive && !spi_serial_data_pin_out);
            serial_data_strong_oe_n  = !(spi_serial_data_pin_drive && spi_serial_data_pin_out);
        end else if (i2c_master) begin
            serial_clock_pin_oe_n = sw_sclk_out;
            serial_data_pin_oe_n  = sw_serial_data_pin_out;
        end
    end

    // Slave-out pin uses the same split drive as master-out.
    assign miso_pin_out     = 1'b0;
    assign miso_pin_oe_n    = !(serial_iface_select && spi_miso_drive
                                && !spi_miso_out);
    assign miso_strong_oe_n = !(serial_iface_select && spi_miso_drive
                                && spi_miso_out);

    // Slave select keeps its weak pull-up always on.
    assign slave_select_pullup_on = 1'b1;
    assign slave_select_n         = sr_s2_q[4];
endmodule

// ---- rtl/ppl_pkg.sv ----
// Package of constants for the port pin logic block.
package ppl_pkg;
    localparam int PORT_W          = 8;
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam int P1_DIG_W        = 2;
    localparam int STRONG_CYC      = 2;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int GLITCH_NS       = 50;
    localparam int GLITCH_CYC      =
        (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int P3_WR_BIT       = 6;
    localparam int P3_RD_BIT       = 7;
    localparam int P3_TXD_BIT      = 1;
    localparam int P3_RXD_BIT      = 0;
    localparam int CNT_W           = 4;
endpackage

// ---- rtl/ppl_pin_cell.sv ----
// Quasi-bidirectional pin cell with timed strong pull-up and keeper.
`timescale 1ns/100ps
module ppl_pin_cell
    import ppl_pkg::*;
#(
    parameter int STRONG = ppl_pkg::STRONG_CYC
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Effective output level and pin sense.
    input  wire logic level,
    input  wire logic pin_sync,
    // Driver controls, enables low while driving; keeper_on is high while the keeper is on.
    output logic      pull_low_oe_n,
    output logic      strong_pullup_oe_n,
    output logic      keeper_on
);
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             lvl_q, lvl_d;
    logic             pl_q, pl_d, st_q, st_d, kp_q, kp_d;

    // A rising level starts the strong pull-up window; keeper turns on once the window ends with level and pin both high.
    always_comb begin
        lvl_d = level;
        cnt_d = cnt_q;
        if (level && !lvl_q) begin
            cnt_d = CNT_W'(STRONG);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
        pl_d = level;
        st_d = !(level && (cnt_d != '0));
        kp_d = level && pin_sync && (cnt_d == '0);
    end

    // State registers.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            lvl_q <= 1'b1;
            pl_q  <= 1'b1;
            st_q  <= 1'b1;
            kp_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
            pl_q  <= pl_d;
            st_q  <= st_d;
            kp_q  <= kp_d;
        end
    end

    assign pull_low_oe_n      = pl_q;
    assign strong_pullup_oe_n = st_q;
    assign keeper_on          = kp_q;
endmodule

// ---- sim/ppl_checker.sv ----
// Concurrent checks on the port pin logic ports.
`timescale 1ns/100ps
module ppl_checker #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic         clk,
    input wire logic         resetn,
    // Watched ports.
    input wire logic [W-1:0] port_one_latch,
    input wire logic [W-1:0] port_two_latch,
    input wire logic [W-1:0] port_three_latch,
    input wire logic         p2_wr,
    input wire logic [W-1:0] p1_in,
    input wire logic [W-1:0] p1_pin_rd,
    input wire logic [1:0]   p1_pull_low_oe_n,
    input wire logic [W-1:2] p1_analog_sel,
    input wire logic         pulse_width_out_zero_route,
    input wire logic         pulse_width_out_zero,
    input wire logic         timer_two_count_in,
    input wire logic         ext_access,
    input wire logic [W-1:0] ext_addr_byte,
    input wire logic [W-1:0] p2_pull_low_oe_n,
    input wire logic [W-1:0] p3_alt_out,
    input wire logic [W-1:0] p3_pull_low_oe_n,
    input wire logic [W-1:0] p3_strong_pullup_oe_n,
    input wire logic         ext_interrupt_zero,
    input wire logic         serial_iface_select,
    input wire logic         serial_clock_strong_oe_n,
    input wire logic         serial_data_strong_oe_n,
    input wire logic         slave_select_pullup_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A latch bit rising with its alternate output high starts a burst.
    sequence s_rise;
        $rose(port_three_latch[0]) && p3_alt_out[0];
    endsequence
    // Strong pull-up on for exactly two cycles, then off.
    sequence s_burst;
        !p3_strong_pullup_oe_n[0] [*2] ##1 p3_strong_pullup_oe_n[0];
    endsequence
    AST_STRONG_TWO: assert property (s_rise |=> s_burst)
        else $error("strong pull-up burst length wrong");
    AST_P1_LEVEL: assert property (p1_pull_low_oe_n[0] ==
        $past(pulse_width_out_zero_route ? pulse_width_out_zero : port_one_latch[0]))
        else $error("port one bit zero drive wrong");
    AST_P2_LEVEL: assert property (p2_pull_low_oe_n ==
        $past(ext_access ? ext_addr_byte : port_two_latch))
        else $error("port two drive wrong");
    AST_P3_LEVEL: assert property (p3_pull_low_oe_n ==
        $past(port_three_latch & p3_alt_out))
        else $error("port three drive wrong");
    AST_P2_HOLD: assert property (ext_access && !p2_wr |=>
        $stable(port_two_latch))
        else $error("port two latch changed by access");
    AST_ANALOG: assert property (
        p1_analog_sel == port_one_latch[W-1:2])
        else $error("analog select differs from latch");
    AST_SYNC_TWO: assert property ($past(resetn, 2) |->
        p1_pin_rd == $past(p1_in, 2))
        else $error("pin readback latency wrong");
    AST_T2_GATE: assert property (!port_one_latch[0] |->
        !timer_two_count_in)
        else $error("timer two input passed with latch low");
    AST_EXT_INTERRUPT_ZERO_GATE: assert property (!port_three_latch[2] |->
        !ext_interrupt_zero)
        else $error("interrupt input passed with latch low");
    AST_I2C_STRONG: assert property (!serial_iface_select &&
        $past(!serial_iface_select) |->
        serial_clock_strong_oe_n && serial_data_strong_oe_n)
        else $error("strong pull-up on in two-wire mode");
    AST_SS_PULLUP: assert property (slave_select_pullup_on)
        else $error("select pull-up off");
endmodule

bind ppl_top ppl_checker #(.W(W)) u_checker (.*);

// ---- sim/ppl_pin_model.sv ----
// Devices and pull-ups on the far side of the pins.
`timescale 1ns/100ps
module ppl_pin_model (
    // Pull-down controls from the block.
    input  wire logic [1:0] p1_pull_low_oe_n,
    input  wire logic [7:0] p2_pull_low_oe_n,
    input  wire logic [7:0] p3_pull_low_oe_n,
    input  wire logic       serial_clock_pin_oe_n,
    input  wire logic       serial_data_pin_oe_n,
    input  wire logic       miso_pin_oe_n,
    // External devices pulling pins low.
    input  wire logic [7:0] ext_low_p1,
    input  wire logic [7:0] ext_low_p2,
    input  wire logic [7:0] ext_low_p3,
    input  wire logic       ext_low_sd,
    input  wire logic       ext_low_ss,
    // Resolved pin levels.
    output logic [7:0]      p1_in,
    output logic [7:0]      p2_in,
    output logic [7:0]      p3_in,
    output logic            serial_clock_pin_in,
    output logic            serial_data_pin_in,
    output logic            miso_pin_in,
    output logic            slave_select_n_in
);
    // A pin sits at its pull-up level unless some party pulls it low.
    assign p1_in = ~ext_low_p1 & {6'h3f, p1_pull_low_oe_n};
    assign p2_in = ~ext_low_p2 & p2_pull_low_oe_n;
    assign p3_in = ~ext_low_p3 & p3_pull_low_oe_n;
    assign serial_clock_pin_in = serial_clock_pin_oe_n;
    assign serial_data_pin_in = serial_data_pin_oe_n & ~ext_low_sd;
    assign miso_pin_in = miso_pin_oe_n;
    // The master selects the device by driving the select line low.
    assign slave_select_n_in = ~ext_low_ss;
endmodule

// ---- sim/port_pin_logic_test.sv ----
// Self-checking testbench for the port pin logic.
`timescale 1ns/100ps
module port_pin_logic_test;
    import ppl_pkg::*;
    logic       clk, resetn, p1_wr, p2_wr, p3_wr, pulse_width_out_zero_route, pulse_width_out_one_route;
    logic       pulse_width_out_zero, pulse_width_out_one, ext_access;
    logic       timer_two_count_in, timer_two_trigger_in, serial_rx_in;
    logic       ext_interrupt_zero, ext_interrupt_one, timer_zero_count_in;
    logic       pulse_width_ext_clock, timer_one_count_in, i2c_master;
    logic       serial_iface_select, sw_sclk_out, sw_serial_data_pin_out, spi_sclk_out;
    logic       spi_serial_data_pin_out, spi_serial_data_pin_drive, spi_sclk_drive, spi_miso_out;
    logic       spi_miso_drive, serial_clock_pin_in, serial_data_pin_in;
    logic       miso_pin_in, serial_clock_pin_oe_n, serial_clock_pin_out;
    logic       serial_clock_strong_oe_n, serial_data_pin_oe_n, miso_pin_oe_n;
    logic       serial_data_pin_out, serial_data_strong_oe_n, miso_pin_out;
    logic       miso_strong_oe_n, spi_sclk_in, spi_serial_data_pin_in, spi_miso_in;
    logic       i2c_sclk_in, i2c_serial_data_pin_in, sw_sclk_in, sw_serial_data_pin_in;
    logic       slave_select_n_in, slave_select_pullup_on, slave_select_n;
    logic       ext_low_sd, ext_low_ss;
    logic [7:0] wr_data, port_one_latch, port_two_latch, port_three_latch;
    logic [7:0] p1_pin_rd, p2_pin_rd, p3_pin_rd, p1_in, p2_in, p3_in;
    logic [7:0] ext_addr_byte, p2_pull_low_oe_n, p2_strong_pullup_oe_n;
    logic [7:0] p2_keeper_on, p3_alt_out, p3_pull_low_oe_n, p3_keeper_on;
    logic [7:0] p3_strong_pullup_oe_n, ext_low_p1, ext_low_p2, ext_low_p3, e;
    logic [1:0] p1_pull_low_oe_n, p1_strong_pullup_oe_n, p1_keeper_on;
    logic [7:2] p1_analog_sel;
    int         fails, n_tests;

    ppl_top u_dut (.*);
    ppl_pin_model u_model (.*);

    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Waits n edges, then steps just past the last one.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle latch write strobe to port p.
    task automatic wr(input int p, input logic [7:0] d);
        wr_data = d;
        p1_wr = (p == 1);
        p2_wr = (p == 2);
        p3_wr = (p == 3);
        cyc(1);
        {p1_wr, p2_wr, p3_wr} = 3'h0;
    endtask

    // Compares one byte-wide result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #200us;
        fails++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        {resetn, p1_wr, p2_wr, p3_wr, pulse_width_out_zero_route, pulse_width_out_one_route} = 6'h0;
        {pulse_width_out_zero, pulse_width_out_one, ext_access} = 3'h0;
        {i2c_master, serial_iface_select, spi_sclk_out, spi_serial_data_pin_out} = 4'h0;
        {spi_serial_data_pin_drive, spi_sclk_drive, spi_miso_out} = 3'h0;
        {spi_miso_drive, ext_low_sd, ext_low_ss} = 3'h0;
        {sw_sclk_out, sw_serial_data_pin_out} = 2'h3;
        {wr_data, ext_addr_byte, ext_low_p1, ext_low_p2, ext_low_p3} = 40'h0;
        p3_alt_out = 8'hff;
        fails = 0;
        n_tests = 0;
        e = 8'h00;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        cyc(3);
        chk(port_one_latch, 8'hff);
        chk(8'(p1_analog_sel), 8'h3f);
        chk(8'({slave_select_pullup_on, slave_select_n}), 8'h03);
        ext_low_ss = 1'b1;
        cyc(3);
        chk(8'(slave_select_n), 8'h00);
        ext_low_ss = 1'b0;
        wr(1, 8'h02);
        cyc(2);
        chk(port_one_latch, 8'h02);
        chk(8'(p1_pull_low_oe_n), 8'h02);
        chk(8'(p1_analog_sel), 8'h00);
        chk(8'(timer_two_count_in), 8'h00);
        ext_low_p1 = 8'h02;
        cyc(3);
        chk(p1_pin_rd, 8'hfc);
        chk(8'(timer_two_trigger_in), 8'h00);
        chk(port_one_latch, 8'h02);
        ext_low_p1 = 8'h00;
        cyc(3);
        chk(8'(timer_two_trigger_in), 8'h01);
        wr(1, 8'hff);
        cyc(2);
        chk(8'(p1_strong_pullup_oe_n), 8'h02);
        cyc(4);
        chk(8'({p1_strong_pullup_oe_n, p1_keeper_on}), 8'h0f);
        {pulse_width_out_zero_route, pulse_width_out_one_route, pulse_width_out_one} = 3'h7;
        wr(1, 8'hfd);
        cyc(2);
        chk(8'(p1_pull_low_oe_n), 8'h02);
        {pulse_width_out_zero_route, pulse_width_out_one_route} = 2'h0;
        cyc(2);
        chk(8'(p1_pull_low_oe_n), 8'h01);
        wr(2, 8'h5a);
        ext_access = 1'b1;
        ext_addr_byte = 8'hc3;
        cyc(2);
        chk(p2_pull_low_oe_n, 8'hc3);
        chk(p2_strong_pullup_oe_n, 8'h3c);
        chk(port_two_latch, 8'h5a);
        ext_access = 1'b0;
        cyc(2);
        chk(p2_pull_low_oe_n, 8'h5a);
        ext_low_p2 = 8'h02;
        cyc(3);
        chk(p2_pin_rd, 8'h58);
        wr(2, port_two_latch ^ 8'hff);
        chk(port_two_latch, 8'ha5);
        ext_low_p2 = 8'h00;
        wr(3, 8'hf0);
        cyc(2);
        chk(p3_pull_low_oe_n, 8'hf0);
        chk(8'(ext_interrupt_zero), 8'h00);
        wr(3, 8'hff);
        p3_alt_out = 8'hfd;
        cyc(2);
        chk(p3_pull_low_oe_n, 8'hfd);
        p3_alt_out = 8'hff;
        for (int i = 0; i < 6; i++) begin
            if (i != 1) begin
                ext_low_p3 = 8'h01 << i;
                cyc(3);
                e = 8'h3f & ~(8'h01 << (i == 0 ? 0 : i - 1));
                if (i == 4) e[5] = 1'b0;
                chk(8'({pulse_width_ext_clock, timer_one_count_in,
                    timer_zero_count_in, ext_interrupt_one,
                    ext_interrupt_zero, serial_rx_in}), e);
                chk(p3_pin_rd, ~(8'h01 << i));
            end
        end
        ext_low_p3 = 8'h00;
        chk(8'({serial_clock_strong_oe_n,
            serial_data_strong_oe_n}), 8'h03);
        ext_low_sd = 1'b1;
        cyc(5);
        ext_low_sd = 1'b0;
        repeat (12) begin
            cyc(1);
            chk(8'(i2c_serial_data_pin_in), 8'h01);
        end
        ext_low_sd = 1'b1;
        cyc(12);
        chk(8'(i2c_serial_data_pin_in), 8'h00);
        ext_low_sd = 1'b0;
        {i2c_master, sw_sclk_out} = 2'h2;
        cyc(4);
        chk(8'({serial_clock_pin_oe_n,
            serial_data_pin_oe_n}), 8'h01);
        chk(8'({sw_sclk_in, sw_serial_data_pin_in}), 8'h01);
        {i2c_master, sw_sclk_out, serial_iface_select} = 3'h3;
        {spi_sclk_drive, spi_sclk_out, spi_miso_drive} = 3'h7;
        cyc(4);
        chk(8'({serial_clock_strong_oe_n, serial_clock_pin_oe_n,
            miso_strong_oe_n, miso_pin_oe_n}), 8'h06);
        chk(8'({spi_sclk_in, spi_serial_data_pin_in, spi_miso_in}), 8'h06);
        print_verdict();
    end
endmodule
